// ===== hdl/hss_pkg.sv
// hss_pkg: constants, types and register map for the host sideband block
package hss_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned FAST_BLINK_MS  = 200;
  localparam int unsigned SLOW_BLINK_MS  = 800;
  localparam int unsigned FAST_BLINK_CYC = FAST_BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_BLINK_CYC = SLOW_BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned STRAP_HOLD_CYC = 16;

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] GPIO_OFS   = 8'h08;

  // ctrl field positions
  localparam int unsigned CTRL_WAKEIN_EN  = 0;
  localparam int unsigned CTRL_WAKEOUT_EN = 1;
  localparam int unsigned CTRL_SLEEP_REQ  = 2;
  localparam int unsigned CTRL_WAKE_AP    = 3;
  localparam int unsigned CTRL_NET_LSB    = 4;
  localparam int unsigned CTRL_SYS_START  = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status field positions
  localparam int unsigned ST_ASLEEP    = 0;
  localparam int unsigned ST_FLIGHT    = 1;
  localparam int unsigned ST_WAKEIN    = 2;
  localparam int unsigned ST_WDOG_DIS  = 3;
  localparam int unsigned ST_USB_DL    = 4;
  localparam int unsigned ST_STARTED   = 5;
  localparam int unsigned ST_WAKE_EVT  = 6;

  // gpio register fields
  localparam int unsigned GPIO_OUT_BIT = 0;
  localparam logic [31:0] GPIO_RST = 32'h0000_0000;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    NET_OFF,
    NET_SEARCH,
    NET_CALL,
    NET_DATA,
    NET_REGISTERED
  } hss_net_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } hss_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } hss_wb_rsp_t;

  typedef struct packed {
    logic hostWakeN;
    logic flightReqN;
    logic flightReqAltN;
    logic bootStrapZero;
    logic usbDlStrap;
    logic powerKeyN;
  } hss_pins_in_t;

endpackage : hss_pkg

// ===== hdl/hss_blink.sv
// hss_blink: network indicator pattern generator
`timescale 1ns/1ps
`default_nettype none

module hss_blink #(
  parameter int unsigned FAST_CYC = hss_pkg::FAST_BLINK_CYC,
  parameter int unsigned SLOW_CYC = hss_pkg::SLOW_BLINK_CYC
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  // pattern select
  input  wire hss_pkg::hss_net_t netState,
  input  wire logic            asleep,
  // led pin, low means lit
  output logic                 networkIndicatorN
);

  localparam int unsigned CW = $clog2(SLOW_CYC + 1);

  logic [CW-1:0] phaseCnt_q;
  logic          phaseOn_q;
  logic [CW-1:0] halfLen;
  logic          lit;

  // ==========================================================
  // phase timing
  // ==========================================================
  always_comb begin
    if (netState == hss_pkg::NET_DATA) begin
      halfLen = CW'(FAST_CYC);
    end else begin
      halfLen = CW'(SLOW_CYC);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseCnt_q <= '0;
      phaseOn_q  <= 1'b1;
    end else if (netState != hss_pkg::NET_DATA &&
                 netState != hss_pkg::NET_REGISTERED) begin
      // restart so a new blink begins with a full lit half
      phaseCnt_q <= '0;
      phaseOn_q  <= 1'b1;
    end else if (phaseCnt_q >= halfLen - CW'(1)) begin
      phaseCnt_q <= '0;
      phaseOn_q  <= ~phaseOn_q;
    end else begin
      phaseCnt_q <= phaseCnt_q + CW'(1);
    end
  end

  // ==========================================================
  // pattern selection
  // ==========================================================
  // pattern per state
  always_comb begin
    unique case (netState)
      hss_pkg::NET_SEARCH,
      hss_pkg::NET_CALL:       lit = 1'b1;
      hss_pkg::NET_DATA,
      hss_pkg::NET_REGISTERED: lit = phaseOn_q;
      default:                 lit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      networkIndicatorN <= 1'b1;
    end else begin
      networkIndicatorN <= ~(lit & ~asleep);
    end
  end

endmodule // hss_blink

`default_nettype wire

// ===== hdl/host_sideband.sv
// host_sideband: wake handshake, status, flight mode, straps, net led
//
// Overview of operation
// - host wake pin: gpio or wake interrupt
// - module wake pin: gpio or ap wake
// - status high asleep, low awake
// - host low on wake pin wakes module
// - no sleep while host wake low
// - drive module wake low to wake ap
// - flight request low turns radio off
// - led patterns follow network state
// - led low lit, high unlit
// - high boot strap disables watchdog
// - download strap plus power key: usb download
// - straps sampled before start, then gpio (here the strap pins are simply ignored after start)
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module host_sideband #(
  parameter int unsigned FAST_CYC = hss_pkg::FAST_BLINK_CYC,
  parameter int unsigned SLOW_CYC = hss_pkg::SLOW_BLINK_CYC
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // wishbone slave
  input  wire hss_pkg::hss_wb_req_t wbReq,
  output hss_pkg::hss_wb_rsp_t      wbRsp,
  // sideband pins in
  input  wire hss_pkg::hss_pins_in_t pinsIn,
  // sideband pins out
  output logic                      moduleWakeOutput,
  output logic                      statusOut,
  output logic                      networkIndicatorN,
  // internal controls
  output logic                      radioEnable,
  output logic                      watchdogDisable,
  output logic                      usbDownloadMode
);

  // ==========================================================
  // synchronisers
  // ==========================================================
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic       hostWakeLow;
  logic       flightLow;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_q <= 3'h7;
      syncB_q <= 3'h7;
    end else begin
      syncA_q <= {pinsIn.flightReqAltN, pinsIn.flightReqN, pinsIn.hostWakeN};
      syncB_q <= syncA_q;
    end
  end

  assign hostWakeLow = ~syncB_q[0];
  // either flight pin name reaches the same function
  assign flightLow   = ~syncB_q[1] | ~syncB_q[2];

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0] ctrl_q;
  logic [31:0] gpio_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wbHit;
  logic        wbWr;

  assign wbHit = wbReq.cyc & wbReq.stb & ~ack_q;
  assign wbWr  = wbHit & wbReq.we;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // write strobe for one register offset
  function automatic logic wrTo(input logic [7:0] ofs);
    return wbWr && (wbReq.adr == ofs);
  endfunction

  // only implemented bits are kept, so reserved bits read back as zero
  localparam logic [31:0] CTRL_MASK =
    (32'h0000_0001 << (hss_pkg::CTRL_SYS_START + 1)) - 32'h0000_0001;
  localparam logic [31:0] GPIO_MASK =
    32'h0000_0001 << hss_pkg::GPIO_OUT_BIT;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= hss_pkg::CTRL_RST;
    end else if (wrTo(hss_pkg::CTRL_OFS)) begin
      ctrl_q <= merge(ctrl_q, wbReq.dat, wbReq.sel) & CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_q <= hss_pkg::GPIO_RST;
    end else if (wrTo(hss_pkg::GPIO_OFS)) begin
      gpio_q <= merge(gpio_q, wbReq.dat, wbReq.sel) & GPIO_MASK;
    end
  end

  logic wakeInEn;
  logic wakeOutEn;
  logic sleepReq;
  logic wakeAp;
  logic sysStart;
  hss_pkg::hss_net_t netState;

  assign wakeInEn  = ctrl_q[hss_pkg::CTRL_WAKEIN_EN];
  assign wakeOutEn = ctrl_q[hss_pkg::CTRL_WAKEOUT_EN];
  assign sleepReq  = ctrl_q[hss_pkg::CTRL_SLEEP_REQ];
  assign wakeAp    = ctrl_q[hss_pkg::CTRL_WAKE_AP];
  assign sysStart  = ctrl_q[hss_pkg::CTRL_SYS_START];

  always_comb begin
    unique case (ctrl_q[hss_pkg::CTRL_NET_LSB +: 3])
      3'h1:    netState = hss_pkg::NET_SEARCH;
      3'h2:    netState = hss_pkg::NET_CALL;
      3'h3:    netState = hss_pkg::NET_DATA;
      3'h4:    netState = hss_pkg::NET_REGISTERED;
      default: netState = hss_pkg::NET_OFF;
    endcase
  end

  // ==========================================================
  // sleep state
  // ==========================================================
  logic asleep_q;
  logic wakeEvt_q;
  logic wakeSrc;

  assign wakeSrc = wakeInEn & hostWakeLow;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asleep_q <= 1'b0;
    end else if (asleep_q) begin
      if (wakeSrc) begin
        asleep_q <= 1'b0;
      end
    end else if (sleepReq && !wakeSrc) begin
      asleep_q <= 1'b1;
    end
  end

  // sticky wake event; a new wake wins over a software clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeEvt_q <= 1'b0;
    end else if (asleep_q && wakeSrc) begin
      wakeEvt_q <= 1'b1;
    end else if (wrTo(hss_pkg::STATUS_OFS) &&
                 wbReq.sel[0] && wbReq.dat[hss_pkg::ST_WAKE_EVT]) begin
      wakeEvt_q <= 1'b0;
    end
  end

  // ==========================================================
  // boot straps
  // ==========================================================
  logic [4:0] strapCnt_q;
  logic       started_q;
  logic       wdogDis_q;
  logic       usbDl_q;

  // hold-off after reset release lets the straps settle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapCnt_q <= 5'h00;
    end else if (strapCnt_q != 5'(hss_pkg::STRAP_HOLD_CYC)) begin
      strapCnt_q <= strapCnt_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      started_q <= 1'b0;
    end else if (sysStart &&
                 strapCnt_q == 5'(hss_pkg::STRAP_HOLD_CYC)) begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdogDis_q <= 1'b0;
      usbDl_q   <= 1'b0;
    end else if (!started_q) begin
      wdogDis_q <= pinsIn.bootStrapZero;
      // strap high with power key low
      usbDl_q   <= pinsIn.usbDlStrap & ~pinsIn.powerKeyN;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // low wakes ap, else gpio
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      moduleWakeOutput <= 1'b1;
    end else begin
      moduleWakeOutput <= wakeOutEn ? ~wakeAp : gpio_q[hss_pkg::GPIO_OUT_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusOut <= 1'b0;
    end else begin
      statusOut <= asleep_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      radioEnable <= 1'b0;
    end else begin
      radioEnable <= ~flightLow;
    end
  end

  // latched strap results
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdogDisable <= 1'b0;
      usbDownloadMode <= 1'b0;
    end else begin
      watchdogDisable <= wdogDis_q;
      usbDownloadMode <= usbDl_q;
    end
  end

  hss_blink #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_blink (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .netState          (netState),
    .asleep            (asleep_q),
    .networkIndicatorN (networkIndicatorN)
  );

  // ==========================================================
  // wishbone answer
  // ==========================================================
  logic [31:0] statusWord;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[hss_pkg::ST_ASLEEP]   = asleep_q;
    statusWord[hss_pkg::ST_FLIGHT]   = flightLow;
    statusWord[hss_pkg::ST_WAKEIN]   = ~syncB_q[0];
    statusWord[hss_pkg::ST_WDOG_DIS] = wdogDis_q;
    statusWord[hss_pkg::ST_USB_DL]   = usbDl_q;
    statusWord[hss_pkg::ST_STARTED]  = started_q;
    statusWord[hss_pkg::ST_WAKE_EVT] = wakeEvt_q;
  end

  // one wait state: ack the cycle after the strobe, then drop
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wbHit;
      if (wbHit) begin
        unique case (wbReq.adr)
          hss_pkg::CTRL_OFS:   rdat_q <= ctrl_q;
          hss_pkg::STATUS_OFS: rdat_q <= statusWord;
          hss_pkg::GPIO_OFS:   rdat_q <= gpio_q;
          default:             rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wbRsp.ack = ack_q;
  assign wbRsp.dat = rdat_q;

endmodule // host_sideband

`default_nettype wire

// ===== testbench/hss_sideband_props.sv
// checker: port assertions of the host sideband block
`timescale 1ns/1ps
`default_nettype none

module hss_sideband_props #(
  parameter int unsigned FAST_CYC = 4,
  parameter int unsigned SLOW_CYC = 16
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  // bus
  input wire hss_pkg::hss_wb_req_t  wbReq,
  input wire hss_pkg::hss_wb_rsp_t  wbRsp,
  // pins and controls
  input wire hss_pkg::hss_pins_in_t pinsIn,
  input wire logic                  moduleWakeOutput,
  input wire logic                  statusOut,
  input wire logic                  networkIndicatorN,
  input wire logic                  radioEnable,
  input wire logic                  watchdogDisable,
  input wire logic                  usbDownloadMode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ctl_q;
  logic       take;
  logic       wakeLow;
  assign take    = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign wakeLow = ctl_q[0] && !pinsIn.hostWakeN;

  // ==========================================
  // control shadow, rebuilt from bus writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) ctl_q <= 8'h00;
    else if (take && wbReq.we && wbReq.adr == hss_pkg::CTRL_OFS
             && wbReq.sel[0]) ctl_q <= wbReq.dat[7:0];
  end

  // ==========================================
  // properties
  AST_ACK_NEXT: assert property (take |=> wbRsp.ack)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  AST_UNMAPPED: assert property (wbRsp.ack && !wbReq.we
    && !(wbReq.adr inside {8'h00, 8'h04, 8'h08}) |-> wbRsp.dat == 32'h0)
    else $error("unmapped read not zero");
  AST_FLIGHT: assert property (
    (!pinsIn.flightReqN || !pinsIn.flightReqAltN)[*3] |=> !radioEnable)
    else $error("radio on while flight requested");
  AST_WAKE_OUT: assert property (
    (ctl_q[1] && $stable(ctl_q))[*2] |-> moduleWakeOutput == !ctl_q[3])
    else $error("wake output not following wake request");
  AST_NO_SLEEP: assert property (wakeLow[*6] |-> !statusOut)
    else $error("asleep while host holds wake low");
  AST_SLEEP: assert property (
    (ctl_q[2] && !wakeLow)[*6] |-> statusOut)
    else $error("not asleep on sleep request");
  AST_LED_SLEEP: assert property (
    statusOut[*2] |-> networkIndicatorN)
    else $error("indicator lit while asleep");
  AST_LED_STEADY: assert property (
    (!statusOut && ctl_q[6:4] inside {3'h1, 3'h2})[*3]
    |-> !networkIndicatorN)
    else $error("indicator not steady on");
  CVR_WAKE: cover property (statusOut ##1 !statusOut);
  CVR_FLIGHT: cover property (!radioEnable);
  CVR_WRITE: cover property (wbRsp.ack && wbReq.we);
endmodule // hss_sideband_props

bind host_sideband hss_sideband_props #(.FAST_CYC(FAST_CYC),
  .SLOW_CYC(SLOW_CYC)) uProps (.core_clk(core_clk), .sys_rst(sys_rst),
  .wbReq(wbReq), .wbRsp(wbRsp), .pinsIn(pinsIn),
  .moduleWakeOutput(moduleWakeOutput), .statusOut(statusOut),
  .networkIndicatorN(networkIndicatorN), .radioEnable(radioEnable),
  .watchdogDisable(watchdogDisable), .usbDownloadMode(usbDownloadMode));
`default_nettype wire

// ===== testbench/hss_host_model.sv
// host model: application processor side of the sideband pins
`timescale 1ns/1ps
`default_nettype none

module hss_host_model #(
  parameter int unsigned KEY_CYC = 64
) (
  // clock
  input  wire logic             core_clk,
  // bench requests
  input  wire logic             wakeReq,
  input  wire logic [1:0]       flightOff,
  input  wire logic [1:0]       straps,
  // module side
  input  wire logic             moduleWakeOutput,
  output hss_pkg::hss_pins_in_t pins,
  output logic                  apWoken
);
  // pulse scaled down so the run stays short
  int unsigned keyCnt_q = KEY_CYC;
  initial pins = 6'b111110;
  initial apWoken = 1'b0;
  always @(posedge core_clk) begin
    if (keyCnt_q != 0) keyCnt_q <= keyCnt_q - 1;
    pins.powerKeyN <= keyCnt_q == 0;
    pins.hostWakeN <= !wakeReq;
    pins.flightReqN <= flightOff[0];
    pins.flightReqAltN <= flightOff[1];
    pins.usbDlStrap <= straps[1];
    pins.bootStrapZero <= straps[0];
    apWoken <= !moduleWakeOutput;
  end
endmodule // hss_host_model
`default_nettype wire

// ===== testbench/host_sideband_bench.sv
// bench for the host sideband block: bus, pins and indicator timing
`timescale 1ns/1ps
`default_nettype none

module host_sideband_bench;
  localparam int unsigned FAST = 4;
  localparam int unsigned SLOW = 16;
  localparam logic [7:0]  CT = hss_pkg::CTRL_OFS;
  localparam logic [7:0]  ST = hss_pkg::STATUS_OFS;
  localparam logic [7:0]  GP = hss_pkg::GPIO_OFS;
  logic                  core_clk  = 1'b0;
  logic                  sys_rst   = 1'b1;
  hss_pkg::hss_wb_req_t  req       = '0;
  hss_pkg::hss_wb_rsp_t  rsp;
  hss_pkg::hss_pins_in_t pins;
  logic                  wakeOut, statusOut, ledN, radioOn;
  logic                  wdogDis, usbDl, apWoken;
  logic                  wakeReq   = 1'b0;
  logic [1:0]            flightOff = 2'b11;
  logic [1:0]            straps    = 2'b11;
  logic [31:0]           rngState  = 32'h6a66e0b8;
  logic [31:0]           rd, r;
  int                    fails = 0, comparisons = 0, cycles = 0, n;

  always #12.5 core_clk = ~core_clk;

  host_sideband #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .wbReq(req), .wbRsp(rsp),
    .pinsIn(pins), .moduleWakeOutput(wakeOut), .statusOut(statusOut),
    .networkIndicatorN(ledN), .radioEnable(radioOn),
    .watchdogDisable(wdogDis), .usbDownloadMode(usbDl));
  hss_host_model uHost (.core_clk(core_clk), .wakeReq(wakeReq),
    .flightOff(flightOff), .straps(straps), .moduleWakeOutput(wakeOut),
    .pins(pins), .apWoken(apWoken));

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  // 99 stands for no edge seen: steady level
  function automatic int halfExp(input int s);
    return s == 3 ? FAST : s == 4 ? SLOW : 99;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge core_clk);
      t++;
    end while (rsp.ack !== 1'b1 && t < 20);
    rd = rsp.dat;
    req <= '0;
    if (t == 20) fails++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // cycles between two indicator edges
  task automatic halfLen();
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = ledN;
      n = 0;
      while (ledN === p && n < 99) begin
        @(negedge core_clk);
        n++;
      end
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    @(negedge core_clk);
    chk({wakeOut, statusOut, ledN, radioOn, wdogDis, usbDl}, 6'b101000);
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    wb(1'b1, CT, 32'h80);
    settle(20);
    chk({wdogDis, usbDl}, 2'b11);
    rdc(ST, 32'h38);
    straps <= 2'b00;
    settle(10);
    chk({wdogDis, usbDl}, 2'b11);
    rdc(GP, hss_pkg::GPIO_RST);
    r = rnd();
    wb(1'b1, GP, r);
    rdc(GP, {31'h0, r[0]});
    wb(1'b1, 8'h0c, rnd());
    rdc(8'h0c, 32'h0);
    wb(1'b1, ST, rnd() & 32'hffff_ffbf);
    rdc(ST, 32'h38);
    rdc(CT, 32'h80);
    for (int i = 0; i < 8; i++) begin
      r = (i < 2) ? 32'(i * 3) : rnd();
      flightOff <= r[1:0];
      settle(4);
      chk(radioOn, &r[1:0]);
      rdc(ST, 32'h38 | {30'h0, ~&r[1:0], 1'b0});
    end
    flightOff <= 2'b11;
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, CT, 32'h80 | (32'(s) << 4));
      settle(40);
      if (halfExp(s) == 99) chk(ledN, s != 1 && s != 2);
      halfLen();
      chk(n, halfExp(s));
    end
    wb(1'b1, GP, 32'h0);
    settle(4);
    chk(wakeOut, 1'b0);
    wb(1'b1, GP, 32'h1);
    settle(4);
    chk(wakeOut, 1'b1);
    wb(1'b1, CT, 32'h8a);
    settle(4);
    chk({wakeOut, apWoken}, 2'b01);
    wb(1'b1, CT, 32'h84);
    settle(6);
    chk({statusOut, ledN}, 2'b11);
    rdc(ST, 32'h39);
    wakeReq <= 1'b1;
    settle(10);
    chk(statusOut, 1'b1);
    rdc(ST, 32'h3d);
    wb(1'b1, CT, 32'h85);
    settle(8);
    chk(statusOut, 1'b0);
    settle(20);
    chk(statusOut, 1'b0);
    rdc(ST, 32'h7c);
    wakeReq <= 1'b0;
    settle(8);
    chk(statusOut, 1'b1);
    wb(1'b1, ST, 32'h40);
    rdc(ST, 32'h39);
    // mid-run reset with key released: straps give no download mode
    straps <= 2'b10;
    sys_rst <= 1'b1;
    settle(2);
    chk({wakeOut, statusOut, ledN, radioOn, wdogDis, usbDl}, 6'b101000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    wb(1'b1, CT, 32'h80);
    settle(20);
    chk({wdogDis, usbDl}, 2'b00);
    rdc(ST, 32'h20);
    end_sim();
  end
endmodule // host_sideband_bench
`default_nettype wire
